// ### hdl/bdc_regs.sv
// Purpose: Status, command, pin override and first configuration registers.
// Assumes: One read or write per cycle on the register port; pins are synchronous.
// Notes: Read data and all control outputs are registered and lag by one cycle.
`timescale 1ns/1ps
module bdc_regs import bdc_pkg::*; (
    input wire logic clk_sys_in,
    input wire logic sys_rst_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic drive_disable_pin_in,
    input wire logic enable_input1_pin_in,
    input wire logic phase_input2_pin_in,
    input wire logic active_state_in,
    input wire logic offstate_diag_comparator_in,
    input wire logic offstate_diag_enable_in,
    input wire logic independent_mode_in,
    input wire logic lowside_load_in,
    input wire logic disable_combine_select_in,
    input wire logic enable1_combine_select_in,
    input wire logic phase2_combine_select_in,
    input wire logic fault_detect_in,
    output logic [7:0] reg_rdata_out,
    output logic reg_rvalid_out,
    output logic fault_clear_cmd_out,
    output logic fault_indication_out,
    output logic fault_indication_oe_out,
    output logic override_unlocked_out,
    output logic config_locked_out,
    output logic bridge1_off_out,
    output logic bridge2_off_out,
    output logic enable_input1_out,
    output logic phase_input2_out,
    output logic active_openload_enable_out,
    output logic [1:0] overvoltage_threshold_select_out,
    output logic overvoltage_detect_enable_out,
    output logic spread_spectrum_enable_out,
    output logic overcurrent_retry_select_out,
    output logic overtemp_retry_select_out,
    output logic overvoltage_retry_select_out,
    output logic openload_retry_select_out
);
    // Returns true when the address selects the given register.
    function automatic logic bdc_hit(input logic [7:0] addr, input logic [7:0] offset);
        bdc_hit = (addr == offset);
    endfunction

    logic [3:0] override_ff;
    logic [3:0] nxt_override;
    logic [7:0] cfg_a_ff;
    logic [7:0] nxt_cfg_a;
    logic [7:0] rdata_ff;
    logic [7:0] nxt_rdata;
    logic rvalid_ff;
    logic clear_ff;
    logic fault_ff;
    logic nxt_fault;
    logic od_level_ff;
    logic unlocked_ff;
    logic cfg_locked_ff;
    logic bridge1_off_ff;
    logic bridge2_off_ff;
    logic enable1_ff;
    logic phase2_ff;
    logic oload_en_ff;
    logic [1:0] ov_sel_ff;
    logic ov_en_ff;
    logic ssc_en_ff;
    logic overcurrent_retry_select_ff;
    logic overtemp_retry_select_ff;
    logic ovolt_retry_ff;
    logic oload_retry_ff;
    logic [1:0] ovr_lock;
    logic [1:0] cfg_lock;
    logic [BDC_NCTL-1:0] ctl_pin;
    logic [BDC_NCTL-1:0] ctl_reg;
    logic [BDC_NCTL-1:0] ctl_sel;
    logic [BDC_NCTL-1:0] ctl_mix;
    logic bridge2_mix;

    // Address decode.
    wire hit_stat_b = bdc_hit(reg_addr_in, BDC_ADDR_STAT_B);
    wire hit_command = bdc_hit(reg_addr_in, BDC_ADDR_COMMAND);
    wire hit_override = bdc_hit(reg_addr_in, BDC_ADDR_OVERRIDE);
    wire hit_cfg_a = bdc_hit(reg_addr_in, BDC_ADDR_CFG_A);
    wire wr_command = reg_wr_in && hit_command;
    wire wr_override = reg_wr_in && hit_override;
    wire ovr_unlocked = (ovr_lock == BDC_OVR_UNLOCKED);
    wire cfg_locked = (cfg_lock == BDC_CFG_LOCKED);
    wire wr_cfg_a = reg_wr_in && hit_cfg_a && !cfg_locked;
    wire clear_req = wr_command && reg_wdata_in[BDC_CMD_CLEAR];

    // Lock fields of the command register.
    bdc_lock_field #(
        .RESET_VAL(BDC_OVR_LOCKED)
    ) u_ovr_lock (
        .clk_sys_in(clk_sys_in),
        .sys_rst_in(sys_rst_in),
        .wr_in(wr_command),
        .wdata_in(reg_wdata_in[BDC_CMD_OVR_HI:BDC_CMD_OVR_LO]),
        .field_out(ovr_lock)
    );

    bdc_lock_field #(
        .RESET_VAL(BDC_CFG_UNLOCKED)
    ) u_cfg_lock (
        .clk_sys_in(clk_sys_in),
        .sys_rst_in(sys_rst_in),
        .wr_in(wr_command),
        .wdata_in(reg_wdata_in[BDC_CMD_CFG_HI:BDC_CMD_CFG_LO]),
        .field_out(cfg_lock)
    );

    // Override register keeps only its four implemented bits.
    assign nxt_override = wr_override ? reg_wdata_in[3:0] : override_ff;

    // Config register write, blocked while locked.
    assign nxt_cfg_a = wr_cfg_a ? reg_wdata_in : cfg_a_ff;

    // Pin combination for the three shared controls.
    assign ctl_pin[BDC_CTL_DIS] = drive_disable_pin_in;
    assign ctl_pin[BDC_CTL_EN1] = enable_input1_pin_in;
    assign ctl_pin[BDC_CTL_PH2] = phase_input2_pin_in;
    assign ctl_reg[BDC_CTL_DIS] = override_ff[BDC_OVR_DIS1];
    assign ctl_reg[BDC_CTL_EN1] = override_ff[BDC_OVR_EN1];
    assign ctl_reg[BDC_CTL_PH2] = override_ff[BDC_OVR_PH2];
    assign ctl_sel[BDC_CTL_DIS] = disable_combine_select_in;
    assign ctl_sel[BDC_CTL_EN1] = enable1_combine_select_in;
    assign ctl_sel[BDC_CTL_PH2] = phase2_combine_select_in;

    genvar gi;
    generate
        for (gi = 0; gi < BDC_NCTL; gi++) begin : g_mix
            bdc_pin_mix u_mix (
                .pin_in(ctl_pin[gi]),
                .reg_bit_in(ctl_reg[gi]),
                .and_sel_in(ctl_sel[gi]),
                .unlocked_in(ovr_unlocked),
                .mix_out(ctl_mix[gi])
            );
        end
    endgenerate

    // Half-bridge 2 has its own register bit in independent mode.
    bdc_pin_mix u_mix_b2 (
        .pin_in(drive_disable_pin_in),
        .reg_bit_in(override_ff[BDC_OVR_DIS2]),
        .and_sel_in(disable_combine_select_in),
        .unlocked_in(ovr_unlocked),
        .mix_out(bridge2_mix)
    );

    wire bridge2_off = independent_mode_in ? bridge2_mix : ctl_mix[BDC_CTL_DIS];

    // Open-load detection is forced off for a low-side load in independent mode.
    wire oload_block = independent_mode_in && lowside_load_in;
    wire oload_en = cfg_a_ff[BDC_CFG_OLOAD] && !oload_block;

    // Overvoltage threshold and its disable code.
    wire [1:0] ov_sel = cfg_a_ff[BDC_CFG_OV_HI:BDC_CFG_OV_LO];
    wire ov_en = (ov_sel != BDC_OV_OFF);

    // Status register built from live inputs; unused bits stay zero.
    wire comp_gate = ovr_unlocked && offstate_diag_enable_in;
    wire [7:0] stat_b_val = {drive_disable_pin_in, 2'h0, active_state_in, 3'h0,
        comp_gate && offstate_diag_comparator_in};

    // Command readback: clear bit reads zero, locks read their state.
    wire [7:0] command_val = {1'b0, 2'h0, ovr_lock, 1'b0, cfg_lock};

    // Read multiplexer with zero for unmapped addresses.
    assign nxt_rdata = hit_stat_b ? stat_b_val :
        hit_command ? command_val :
        hit_override ? {4'h0, override_ff} :
        hit_cfg_a ? cfg_a_ff : BDC_ZERO;

    // Fault indication latch: a new detection wins over a clear.
    assign nxt_fault = fault_detect_in ? 1'b1 : (clear_req ? 1'b0 : fault_ff);

    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            override_ff <= BDC_RST_OVERRIDE[3:0];
            cfg_a_ff <= BDC_RST_CFG_A;
        end else begin
            override_ff <= nxt_override;
            cfg_a_ff <= nxt_cfg_a;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            rdata_ff <= BDC_ZERO;
            rvalid_ff <= 1'b0;
        end else begin
            rdata_ff <= reg_rd_in ? nxt_rdata : rdata_ff;
            rvalid_ff <= reg_rd_in;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            clear_ff <= 1'b0;
            fault_ff <= 1'b0;
            od_level_ff <= 1'b0;
        end else begin
            clear_ff <= clear_req;
            fault_ff <= nxt_fault;
            od_level_ff <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            unlocked_ff <= 1'b0;
            cfg_locked_ff <= 1'b0;
            bridge1_off_ff <= BDC_RST_OVERRIDE[BDC_OVR_DIS1];
            bridge2_off_ff <= BDC_RST_OVERRIDE[BDC_OVR_DIS2];
            enable1_ff <= 1'b0;
            phase2_ff <= 1'b0;
        end else begin
            unlocked_ff <= ovr_unlocked;
            cfg_locked_ff <= cfg_locked;
            bridge1_off_ff <= ctl_mix[BDC_CTL_DIS];
            bridge2_off_ff <= bridge2_off;
            enable1_ff <= ctl_mix[BDC_CTL_EN1];
            phase2_ff <= ctl_mix[BDC_CTL_PH2];
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            oload_en_ff <= BDC_RST_CFG_A[BDC_CFG_OLOAD];
            ov_sel_ff <= BDC_RST_CFG_A[BDC_CFG_OV_HI:BDC_CFG_OV_LO];
            ov_en_ff <= 1'b1;
            ssc_en_ff <= !BDC_RST_CFG_A[BDC_CFG_SSC];
            overcurrent_retry_select_ff <= BDC_RST_CFG_A[BDC_CFG_OCP];
            overtemp_retry_select_ff <= BDC_RST_CFG_A[BDC_CFG_OTD];
            ovolt_retry_ff <= BDC_RST_CFG_A[BDC_CFG_VMR];
            oload_retry_ff <= BDC_RST_CFG_A[BDC_CFG_OLR];
        end else begin
            oload_en_ff <= oload_en;
            ov_sel_ff <= ov_sel;
            ov_en_ff <= ov_en;
            ssc_en_ff <= !cfg_a_ff[BDC_CFG_SSC];
            overcurrent_retry_select_ff <= cfg_a_ff[BDC_CFG_OCP];
            overtemp_retry_select_ff <= cfg_a_ff[BDC_CFG_OTD];
            ovolt_retry_ff <= cfg_a_ff[BDC_CFG_VMR];
            oload_retry_ff <= cfg_a_ff[BDC_CFG_OLR];
        end
    end

    assign reg_rdata_out = rdata_ff;
    assign reg_rvalid_out = rvalid_ff;
    assign fault_clear_cmd_out = clear_ff;
    assign fault_indication_out = od_level_ff;
    assign fault_indication_oe_out = fault_ff;
    assign override_unlocked_out = unlocked_ff;
    assign config_locked_out = cfg_locked_ff;
    assign bridge1_off_out = bridge1_off_ff;
    assign bridge2_off_out = bridge2_off_ff;
    assign enable_input1_out = enable1_ff;
    assign phase_input2_out = phase2_ff;
    assign active_openload_enable_out = oload_en_ff;
    assign overvoltage_threshold_select_out = ov_sel_ff;
    assign overvoltage_detect_enable_out = ov_en_ff;
    assign spread_spectrum_enable_out = ssc_en_ff;
    assign overcurrent_retry_select_out = overcurrent_retry_select_ff;
    assign overtemp_retry_select_out = overtemp_retry_select_ff;
    assign overvoltage_retry_select_out = ovolt_retry_ff;
    assign openload_retry_select_out = oload_retry_ff;
endmodule

// ### hdl/bdc_pkg.sv
// Purpose: Constants for the bridge driver control register slice.
// Assumes: Eight-bit register addresses and data, one register access per cycle.
// Notes: Field positions and reset values are named here; the status and command readback in the logic use literal bit positions.
//
// Operation
// - Status bit 7 mirrors disable pin level.
// - Status bit 4 shows the active state.
// - Status bit 0 shows gated off-state comparator.
// - Command bit 7 clears faults, releases indication.
// - Override lock field: 01 locks, 10 unlocks.
// - Config lock field: 01 unlocks, 10 locks.
// - Override bit 3 substitutes disable pin, bridge 1.
// - Override bit 2 disables half-bridge 2 in independent mode.
// - Override bit 1 substitutes enable/input-1 pin.
// - Override bit 0 substitutes phase/input-2 pin.
// - Config bit 7 enables active open-load detection.
// - Independent mode low-side load blocks open-load detection.
// - Threshold select 00/01/10 levels, 11 disables.
// - Config bit 4 set turns spread spectrum off.
// - Config bit 3 selects overcurrent retry.
// - Config bit 2 selects overtemperature retry.
// - Unimplemented bits read zero, writes ignored.
// - Unlocked pins combine with register: OR/AND.
package bdc_pkg;
    localparam int BDC_AW = 8;
    localparam int BDC_DW = 8;
    localparam logic [7:0] BDC_ADDR_STAT_B = 8'h03;
    localparam logic [7:0] BDC_ADDR_COMMAND = 8'h08;
    localparam logic [7:0] BDC_ADDR_OVERRIDE = 8'h09;
    localparam logic [7:0] BDC_ADDR_CFG_A = 8'h0a;
    localparam logic [7:0] BDC_RST_STAT_B = 8'h80;
    localparam logic [7:0] BDC_RST_COMMAND = 8'h09;
    localparam logic [7:0] BDC_RST_OVERRIDE = 8'h0c;
    localparam logic [7:0] BDC_RST_CFG_A = 8'h10;
    localparam logic [7:0] BDC_ZERO = 8'h00;
    localparam int BDC_ST2_PIN = 7;
    localparam int BDC_ST2_ACTIVE = 4;
    localparam int BDC_ST2_COMP = 0;
    localparam int BDC_CMD_CLEAR = 7;
    localparam int BDC_CMD_OVR_HI = 4;
    localparam int BDC_CMD_OVR_LO = 3;
    localparam int BDC_CMD_CFG_HI = 1;
    localparam int BDC_CMD_CFG_LO = 0;
    localparam int BDC_OVR_DIS1 = 3;
    localparam int BDC_OVR_DIS2 = 2;
    localparam int BDC_OVR_EN1 = 1;
    localparam int BDC_OVR_PH2 = 0;
    localparam logic [7:0] BDC_OVR_MASK = 8'h0f;
    localparam int BDC_CFG_OLOAD = 7;
    localparam int BDC_CFG_OV_HI = 6;
    localparam int BDC_CFG_OV_LO = 5;
    localparam int BDC_CFG_SSC = 4;
    localparam int BDC_CFG_OCP = 3;
    localparam int BDC_CFG_OTD = 2;
    localparam int BDC_CFG_VMR = 1;
    localparam int BDC_CFG_OLR = 0;
    localparam logic [1:0] BDC_LOCK_A = 2'h1;
    localparam logic [1:0] BDC_LOCK_B = 2'h2;
    localparam logic [1:0] BDC_OVR_LOCKED = 2'h1;
    localparam logic [1:0] BDC_OVR_UNLOCKED = 2'h2;
    localparam logic [1:0] BDC_CFG_UNLOCKED = 2'h1;
    localparam logic [1:0] BDC_CFG_LOCKED = 2'h2;
    localparam logic [1:0] BDC_OV_35V = 2'h0;
    localparam logic [1:0] BDC_OV_28V = 2'h1;
    localparam logic [1:0] BDC_OV_18V = 2'h2;
    localparam logic [1:0] BDC_OV_OFF = 2'h3;
    localparam int BDC_NCTL = 3;
    localparam int BDC_CTL_DIS = 0;
    localparam int BDC_CTL_EN1 = 1;
    localparam int BDC_CTL_PH2 = 2;
endpackage

// ### hdl/bdc_lock_field.sv
// Purpose: Two-bit lock field that accepts only the two valid codes.
// Assumes: Write strobe and data are synchronous to the clock.
// Notes: Invalid codes leave the stored value unchanged.
`timescale 1ns/1ps
module bdc_lock_field import bdc_pkg::*; #(
    parameter logic [1:0] RESET_VAL = 2'h1
) (
    input wire logic clk_sys_in,
    input wire logic sys_rst_in,
    input wire logic wr_in,
    input wire logic [1:0] wdata_in,
    output logic [1:0] field_out
);
    logic [1:0] field_ff;
    logic [1:0] nxt_field;
    wire code_ok = (wdata_in == BDC_LOCK_A) || (wdata_in == BDC_LOCK_B);

    // Codes 00 and 11 are discarded.
    assign nxt_field = (wr_in && code_ok) ? wdata_in : field_ff;

    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            field_ff <= RESET_VAL;
        end else begin
            field_ff <= nxt_field;
        end
    end

    assign field_out = field_ff;
endmodule

// ### hdl/bdc_pin_mix.sv
// Purpose: Combines one control pin with its register substitute.
// Assumes: All inputs are synchronous to the system clock.
// Notes: Purely combinational; the caller registers the result.
`timescale 1ns/1ps
module bdc_pin_mix (
    input wire logic pin_in,
    input wire logic reg_bit_in,
    input wire logic and_sel_in,
    input wire logic unlocked_in,
    output logic mix_out
);
    wire combined = and_sel_in ? (pin_in & reg_bit_in) : (pin_in | reg_bit_in);

    // A locked override leaves the pin in sole control.
    assign mix_out = unlocked_in ? combined : pin_in;
endmodule

// ### tb/bdc_regs_monitor.sv
// Purpose: Concurrent checks on the register slice ports.
// Assumes: One clock, synchronous active-high reset.
// Notes: Bound to every instance of the register slice.
`timescale 1ns/1ps
module bdc_regs_monitor (
    input wire logic clk_sys_in,
    input wire logic sys_rst_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic drive_disable_pin_in,
    input wire logic enable_input1_pin_in,
    input wire logic independent_mode_in,
    input wire logic lowside_load_in,
    input wire logic fault_detect_in,
    input wire logic [7:0] reg_rdata_out,
    input wire logic reg_rvalid_out,
    input wire logic fault_indication_oe_out,
    input wire logic override_unlocked_out,
    input wire logic config_locked_out,
    input wire logic enable_input1_out,
    input wire logic active_openload_enable_out,
    input wire logic [1:0] overvoltage_threshold_select_out,
    input wire logic overvoltage_detect_enable_out,
    input wire logic overcurrent_retry_select_out
);
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (sys_rst_in);
    wire logic cmd_wr = reg_wr_in && (reg_addr_in == 8'h08);
    wire logic stat_rd = reg_rd_in && (reg_addr_in == 8'h03);
    wire logic cmd_rd = reg_rd_in && (reg_addr_in == 8'h08);
    wire logic cfg_wr = reg_wr_in && (reg_addr_in == 8'h0a);
    wire logic oload_block = independent_mode_in && lowside_load_in;
    property p_pin;
        stat_rd |=> reg_rdata_out[7] == $past(drive_disable_pin_in);
    endproperty
    a_pin: assert property (p_pin) else $error("status pin bit wrong");
    property p_clr; cmd_wr && reg_wdata_in[7] && !fault_detect_in |=> !fault_indication_oe_out;
    endproperty
    a_clr: assert property (p_clr) else $error("fault line not released");
    property p_set; fault_detect_in |=> fault_indication_oe_out;
    endproperty
    a_set: assert property (p_set) else $error("fault line not driven");
    property p_unl; cmd_wr && reg_wdata_in[4:3] == 2'h2 |-> ##2 override_unlocked_out;
    endproperty
    a_unl: assert property (p_unl) else $error("override not unlocked");
    property p_oload;
        !$past(sys_rst_in) && $past(oload_block) |-> !active_openload_enable_out;
    endproperty
    a_oload: assert property (p_oload) else $error("open-load detect on for low-side load");
    property p_ov; overvoltage_detect_enable_out == (overvoltage_threshold_select_out != 2'h3);
    endproperty
    a_ov: assert property (p_ov) else $error("overvoltage enable mismatch");
    property p_zero;
        cmd_rd |=> reg_rvalid_out && (reg_rdata_out & 8'he4) == 8'h00;
    endproperty
    a_zero: assert property (p_zero) else $error("command unused bits not zero");
    property p_lock;
        cfg_wr ##1 config_locked_out |=> $stable(overcurrent_retry_select_out);
    endproperty
    a_lock: assert property (p_lock) else $error("locked config changed");
    property p_pins;
        !$past(sys_rst_in) && !override_unlocked_out && $past(!override_unlocked_out)
            |-> enable_input1_out == $past(enable_input1_pin_in);
    endproperty
    a_pins: assert property (p_pins) else $error("locked control not from pin");
endmodule
bind bdc_regs bdc_regs_monitor u_mon (.*);

// ### tb/bdc_host_model.sv
// Purpose: Controller side of the register port.
// Assumes: Requests change at the falling clock edge.
// Notes: Released address and data lines show the inverse of their last value.
`timescale 1ns/1ps
module bdc_host_model (
    input wire logic clk_sys_in,
    input wire logic [7:0] reg_rdata_in,
    input wire logic reg_rvalid_in,
    output logic [7:0] reg_addr_out = 8'h00,
    output logic [7:0] reg_wdata_out = 8'h00,
    output logic reg_wr_out = 1'b0,
    output logic reg_rd_out = 1'b0
);
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_sys_in);
        reg_addr_out = a;
        reg_wdata_out = d;
        reg_wr_out = 1'b1;
        @(negedge clk_sys_in);
        reg_wr_out = 1'b0;
        reg_addr_out = ~a;
        reg_wdata_out = ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
        @(negedge clk_sys_in);
        reg_addr_out = a;
        reg_rd_out = 1'b1;
        @(negedge clk_sys_in);
        d = reg_rdata_in;
        v = reg_rvalid_in;
        reg_rd_out = 1'b0;
        reg_addr_out = ~a;
    endtask
endmodule

// ### tb/bdc_regs_test.sv
// Purpose: Self-checking bench for the register slice.
// Assumes: Inputs change at the falling clock edge.
// Notes: Each scenario task drives and judges by itself.
`timescale 1ns/1ps
module bdc_regs_test;
    logic clk_sys_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out, rv;
    logic reg_wr_in, reg_rd_in, reg_rvalid_out, vv;
    logic drive_disable_pin_in = 1'b1, enable_input1_pin_in = 1'b0, phase_input2_pin_in = 1'b0;
    logic active_state_in = 1'b0, offstate_diag_comparator_in = 1'b0;
    logic offstate_diag_enable_in = 1'b0;
    logic independent_mode_in = 1'b0, lowside_load_in = 1'b0, fault_detect_in = 1'b0;
    logic disable_combine_select_in = 1'b0, enable1_combine_select_in = 1'b0;
    logic phase2_combine_select_in = 1'b0;
    logic fault_clear_cmd_out, fault_indication_out, fault_indication_oe_out;
    logic override_unlocked_out, config_locked_out, bridge1_off_out, bridge2_off_out;
    logic enable_input1_out, phase_input2_out, active_openload_enable_out;
    logic [1:0] overvoltage_threshold_select_out;
    logic overvoltage_detect_enable_out, spread_spectrum_enable_out, overcurrent_retry_select_out;
    logic overtemp_retry_select_out, overvoltage_retry_select_out, openload_retry_select_out;
    int err_total = 0;
    int num_checks = 0;
    always #5 clk_sys_in = ~clk_sys_in;
    bdc_regs dut (.*);
    bdc_host_model host (.clk_sys_in(clk_sys_in), .reg_rdata_in(reg_rdata_out),
        .reg_rvalid_in(reg_rvalid_out), .reg_addr_out(reg_addr_in),
        .reg_wdata_out(reg_wdata_in), .reg_wr_out(reg_wr_in), .reg_rd_out(reg_rd_in));
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        num_checks++;
        if (g !== e) begin
            err_total++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic rdchk(input string n, input logic [7:0] a, input logic [7:0] e);
        host.rd(a, rv, vv);
        if (vv !== 1'b1) rv = 8'hxx;
        chk(n, e, rv);
    endtask
    task automatic settle;
        repeat (2) @(negedge clk_sys_in);
    endtask
    task automatic conclude;
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic t_reset;
        rdchk("stat_b", 8'h03, 8'h80);
        rdchk("command", 8'h08, 8'h09);
        rdchk("override", 8'h09, 8'h0c);
        rdchk("cfg_a", 8'h0a, 8'h10);
        rdchk("unmapped", 8'h05, 8'h00);
        chk("bridge1_off", 1, bridge1_off_out);
    endtask
    task automatic t_locks;
        host.wr(8'h08, 8'h7f);
        rdchk("bad codes", 8'h08, 8'h09);
        host.wr(8'h08, 8'h92);
        chk("clear pulse", 1, fault_clear_cmd_out);
        rdchk("flipped", 8'h08, 8'h12);
        chk("cfg locked", 1, config_locked_out);
        host.wr(8'h08, 8'h00);
        rdchk("zero codes", 8'h08, 8'h12);
        host.wr(8'h08, 8'h09);
        rdchk("restored", 8'h08, 8'h09);
    endtask
    task automatic t_config;
        host.wr(8'h0a, 8'h8f);
        settle;
        chk("oload_en", 1, active_openload_enable_out);
        chk("ssc_en", 1, spread_spectrum_enable_out);
        chk("ocp", 1, overcurrent_retry_select_out);
        chk("otd", 1, overtemp_retry_select_out);
        chk("ovolt retry", 1, overvoltage_retry_select_out);
        chk("oload retry", 1, openload_retry_select_out);
        rdchk("cfg_a rb", 8'h0a, 8'h8f);
        independent_mode_in = 1'b1;
        lowside_load_in = 1'b1;
        settle;
        chk("oload low-side", 0, active_openload_enable_out);
        independent_mode_in = 1'b0;
        lowside_load_in = 1'b0;
        for (int i = 0; i < 4; i++) begin
            host.wr(8'h0a, 8'(i << 5));
            settle;
            chk("ov_sel", 8'(i), {6'h00, overvoltage_threshold_select_out});
            chk("ov_en", 8'(i != 3), {7'h00, overvoltage_detect_enable_out});
        end
        host.wr(8'h08, 8'h0a);
        settle;
        host.wr(8'h0a, 8'hff);
        rdchk("locked cfg", 8'h0a, 8'h60);
        chk("ocp locked", 0, overcurrent_retry_select_out);
        chk("ovolt locked", 0, overvoltage_retry_select_out);
        host.wr(8'h08, 8'h09);
    endtask
    task automatic t_override;
        host.wr(8'h09, 8'hf3);
        rdchk("override rb", 8'h09, 8'h03);
        settle;
        chk("en1 locked", 0, enable_input1_out);
        host.wr(8'h08, 8'h11);
        settle;
        chk("en1 or", 1, enable_input1_out);
        chk("ph2 or", 1, phase_input2_out);
        enable1_combine_select_in = 1'b1;
        phase2_combine_select_in = 1'b1;
        settle;
        chk("en1 and", 0, enable_input1_out);
        chk("ph2 and", 0, phase_input2_out);
        host.wr(8'h09, 8'h04);
        drive_disable_pin_in = 1'b0;
        independent_mode_in = 1'b1;
        settle;
        chk("bridge1", 0, bridge1_off_out);
        chk("bridge2", 1, bridge2_off_out);
        active_state_in = 1'b1;
        offstate_diag_comparator_in = 1'b1;
        offstate_diag_enable_in = 1'b1;
        rdchk("status live", 8'h03, 8'h11);
        host.wr(8'h08, 8'h09);
        settle;
        rdchk("status locked", 8'h03, 8'h10);
        independent_mode_in = 1'b0;
    endtask
    task automatic t_fault;
        fault_detect_in = 1'b1;
        @(negedge clk_sys_in);
        fault_detect_in = 1'b0;
        chk("fault set", 1, fault_indication_oe_out);
        chk("fault level", 0, fault_indication_out);
        host.wr(8'h08, 8'h89);
        chk("fault clear", 0, fault_indication_oe_out);
    endtask
    initial begin
        #20000;
        err_total++;
        conclude;
    end
    initial begin
        repeat (8) @(negedge clk_sys_in);
        sys_rst_in = 1'b0;
        t_reset;
        t_locks;
        t_config;
        t_override;
        t_fault;
        conclude;
    end
endmodule
